// [src/gpc_regs.svh]
// Register offsets, reset values and field positions of the pin banks
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

// ============================================================
// Register offsets on the file-register port
`define GPC_ADDR_BANK_A_DATA 8'h05
`define GPC_ADDR_BANK_B_DATA 8'h06
`define GPC_ADDR_OPTION 8'h81
`define GPC_ADDR_BANK_A_DIR 8'h85
`define GPC_ADDR_BANK_B_DIR 8'h86

// ============================================================
// Reset values
`define GPC_RST_OPTION 8'hFF
`define GPC_RST_BANK_A_DIR 5'h1F
`define GPC_RST_BANK_B_DIR 8'hFF
`define GPC_RST_LATCH_A 5'h00
`define GPC_RST_LATCH_B 8'h00
`define GPC_RST_BYTE 8'h00

// ============================================================
// Field positions
`define GPC_OPT_PULLUP_BIT 7
`define GPC_PA_MSB 4
`define GPC_PA_OD_BIT 4
`define GPC_PA_CMP_LO_BIT 3
`define GPC_PB_CHG_MSB 7
`define GPC_PB_CHG_LSB 4
`define GPC_PA_PAD 3'h0

`endif

// [src/gpc_pkg.sv]
// Types shared by the pin bank block
package gpc_pkg;
   // Full register byte
   typedef logic [7:0] gpc_byte_t;
   // First bank: five pins
   typedef logic [4:0] gpc_bank_a_t;
   // Second bank: eight pins
   typedef logic [7:0] gpc_bank_b_t;
   // Change-detect nibble of the second bank
   typedef logic [3:0] gpc_nibble_t;
endpackage

// [src/gpc_sync.sv]
// Two-flop synchroniser for the pin inputs of both banks
`timescale 1ns/1ps
module gpc_sync
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire gpc_pkg::gpc_bank_a_t i_pa_async,
   input wire gpc_pkg::gpc_bank_b_t i_pb_async,
   output gpc_pkg::gpc_bank_a_t o_pa_sync,
   output gpc_pkg::gpc_bank_b_t o_pb_sync
);
   import gpc_pkg::*;

   // ============================================================
   // Synchroniser stages, one generate loop over all thirteen pins
   logic [12:0] raw_w;   // Pins as they arrive
   logic [12:0] meta_r;  // First stage, read only by the second
   logic [12:0] sync_r;  // Second stage, safe to use

   assign raw_w = {i_pb_async, i_pa_async};

   genvar gi;
   generate
      for (gi = 0; gi < 13; gi = gi + 1)
      begin : g_bit
         // Two flops per pin
         always_ff @(posedge i_core_clk)
         begin
            if (i_sys_rst)
            begin
               meta_r[gi] <= 1'h0;
               sync_r[gi] <= 1'h0;
            end
            else
            begin
               meta_r[gi] <= raw_w[gi];
               sync_r[gi] <= meta_r[gi];
            end
         end
      end
   endgenerate

   assign o_pa_sync = sync_r[4:0];
   assign o_pb_sync = sync_r[12:5];
endmodule

// [src/gpc_chg_det.sv]
// Change detection on the upper nibble of the second bank
`timescale 1ns/1ps
module gpc_chg_det
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire gpc_pkg::gpc_nibble_t i_pins,
   input wire gpc_pkg::gpc_nibble_t i_dir,
   input wire logic i_snap,
   input wire logic i_flag_clr,
   output logic o_flag,
   output logic o_mismatch
);
   import gpc_pkg::*;

   // ============================================================
   // Comparison against the value seen at the last bank access
   gpc_nibble_t old_r;     // Value latched at last read or write
   gpc_nibble_t miss_w;    // Per-pin mismatch, inputs only
   logic any_miss_w;       // OR of all mismatches
   logic flag_r;           // Sticky change flag
   logic flag_nxt;         // Next flag value

   assign miss_w = (i_pins ^ old_r) & i_dir;
   assign any_miss_w = |miss_w;
   // Set wins over a clear in the same cycle
   assign flag_nxt = any_miss_w | (flag_r & ~i_flag_clr);

   // Old value reload and sticky flag
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         old_r <= i_pins;
         flag_r <= 1'h0;
      end
      else
      begin
         // Any access to the bank ends the mismatch
         if (i_snap)
         begin
            old_r <= i_pins;
         end
         flag_r <= flag_nxt;
      end
   end

   assign o_flag = flag_r;
   assign o_mismatch = any_miss_w;
endmodule

// [src/gpc_top.sv]
// Two general-purpose pin banks with change detection on the second
`timescale 1ns/1ps
`include "gpc_regs.svh"
// Summary of operation
// - Bank A direction one floats, zero drives
// - Bank A read gives pins, write sets latch
// - Every write stores into latches, inputs too
// - Bank A five bits; direction 7:5 read zero
// - Pin four open drain, feeds timer clock
// - Comparator-input pins read back as zero
// - Reset makes all bank A pins inputs
// - Direction bits still rule comparator pins
// - Comparator outputs need direction 4:3 cleared
// - Bank B eight bits with own direction
// - Bank B read gives pins, write sets latch
// - Option bit seven low enables all pull-ups
// - Pull-up off when pin is output
// - Pull-ups disabled after reset
// - Only input pins 7:4 take part
// - Mismatches ORed into bank B change flag
// - Mismatch keeps setting flag; access ends it
// - Change flag can wake from sleep
// - Change during a read still sets the flag
module gpc_top
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_reg_addr,
   input wire gpc_pkg::gpc_byte_t i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output gpc_pkg::gpc_byte_t o_reg_rdata,
   input wire gpc_pkg::gpc_bank_a_t i_cmp_analog_sel,
   input wire logic i_cmp_out_route,
   input wire logic [1:0] i_cmp_out,
   input wire logic i_change_flag_clr,
   input wire gpc_pkg::gpc_bank_a_t i_pa_in,
   output gpc_pkg::gpc_bank_a_t o_pa_out,
   output gpc_pkg::gpc_bank_a_t o_pa_oe,
   input wire gpc_pkg::gpc_bank_b_t i_pb_in,
   output gpc_pkg::gpc_bank_b_t o_pb_out,
   output gpc_pkg::gpc_bank_b_t o_pb_oe,
   output gpc_pkg::gpc_bank_b_t o_pb_pullup_en,
   output logic o_timer_ext_clock_in,
   output logic o_bank_b_change_flag,
   output logic o_wake_req
);
   import gpc_pkg::*;

   // ============================================================
   // Pin input synchronisation
   gpc_bank_a_t pa_sync_w;  // Bank A pins, clock domain safe
   gpc_bank_b_t pb_sync_w;  // Bank B pins, clock domain safe

   // Both banks pass two flops before any read or compare
   gpc_sync u_sync
   (
      .i_core_clk (i_core_clk),
      .i_sys_rst (i_sys_rst),
      .i_pa_async (i_pa_in),
      .i_pb_async (i_pb_in),
      .o_pa_sync (pa_sync_w),
      .o_pb_sync (pb_sync_w)
   );

   // ============================================================
   // Address decode
   logic sel_a_data_w;   // Bank A data selected
   logic sel_b_data_w;   // Bank B data selected
   logic sel_opt_w;      // Option register selected
   logic sel_a_dir_w;    // Bank A direction selected
   logic sel_b_dir_w;    // Bank B direction selected
   logic wr_a_data_w;    // Write strobes per register
   logic wr_b_data_w;
   logic wr_opt_w;
   logic wr_a_dir_w;
   logic wr_b_dir_w;
   logic b_access_w;     // Any read or write of bank B data

   assign sel_a_data_w = (i_reg_addr == `GPC_ADDR_BANK_A_DATA);
   assign sel_b_data_w = (i_reg_addr == `GPC_ADDR_BANK_B_DATA);
   assign sel_opt_w = (i_reg_addr == `GPC_ADDR_OPTION);
   assign sel_a_dir_w = (i_reg_addr == `GPC_ADDR_BANK_A_DIR);
   assign sel_b_dir_w = (i_reg_addr == `GPC_ADDR_BANK_B_DIR);
   assign wr_a_data_w = i_reg_wr & sel_a_data_w;
   assign wr_b_data_w = i_reg_wr & sel_b_data_w;
   assign wr_opt_w = i_reg_wr & sel_opt_w;
   assign wr_a_dir_w = i_reg_wr & sel_a_dir_w;
   assign wr_b_dir_w = i_reg_wr & sel_b_dir_w;
   assign b_access_w = (i_reg_wr | i_reg_rd) & sel_b_data_w;

   // ============================================================
   // Software registers
   gpc_bank_a_t latch_a_r;  // Bank A output latch
   gpc_bank_a_t dir_a_r;    // Bank A direction, one is input
   gpc_bank_b_t latch_b_r;  // Bank B output latch
   gpc_bank_b_t dir_b_r;    // Bank B direction, one is input
   gpc_byte_t option_r;     // Option register, bit 7 pull-up control

   // Register writes; the CPU has already merged pin values and
   // the change, so the whole byte lands in the latch, inputs too
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         latch_a_r <= `GPC_RST_LATCH_A;
         dir_a_r <= `GPC_RST_BANK_A_DIR;
         latch_b_r <= `GPC_RST_LATCH_B;
         dir_b_r <= `GPC_RST_BANK_B_DIR;
         option_r <= `GPC_RST_OPTION;
      end
      else
      begin
         // Bank A data: only the latch changes
         if (wr_a_data_w)
         begin
            latch_a_r <= i_reg_wdata[`GPC_PA_MSB:0];
         end
         // Bank A direction: five bits kept
         if (wr_a_dir_w)
         begin
            dir_a_r <= i_reg_wdata[`GPC_PA_MSB:0];
         end
         // Bank B data: only the latch changes
         if (wr_b_data_w)
         begin
            latch_b_r <= i_reg_wdata;
         end
         // Bank B direction
         if (wr_b_dir_w)
         begin
            dir_b_r <= i_reg_wdata;
         end
         // Option register
         if (wr_opt_w)
         begin
            option_r <= i_reg_wdata;
         end
      end
   end

   // ============================================================
   // Bank A pin drive
   gpc_bank_a_t pa_val_w;    // Value offered to each pin
   gpc_bank_a_t pa_oe_nxt;   // Next output enables
   gpc_bank_a_t pa_out_nxt;  // Next output levels
   logic pa_od_low_w;        // Open-drain pin pulls low

   // Comparator results replace latch bits 3 and 4 when routed
   assign pa_val_w = i_cmp_out_route ?
      {i_cmp_out, latch_a_r[2:0]} : latch_a_r;
   assign pa_od_low_w = ~pa_val_w[`GPC_PA_OD_BIT];
   // Direction rules every pin, comparator use or not
   assign pa_oe_nxt = {~dir_a_r[`GPC_PA_OD_BIT] & pa_od_low_w,
      ~dir_a_r[3:0]};
   // Open-drain pin only ever drives a low
   assign pa_out_nxt = {1'h0, pa_val_w[3:0]};

   // ============================================================
   // Bank B pin drive and pull-ups
   gpc_bank_b_t pb_pu_nxt;   // Next pull-up enables
   logic pullup_disable_n_w; // Option bit 7, low turns pull-ups on

   assign pullup_disable_n_w = option_r[`GPC_OPT_PULLUP_BIT];
   // Pull-ups on only for input pins while the option bit is low
   assign pb_pu_nxt = {8{~pullup_disable_n_w}} & dir_b_r;

   // ============================================================
   // Read data
   gpc_bank_a_t pa_read_w;  // Bank A pins as software sees them
   gpc_byte_t rdata_nxt;    // Next read data

   // Comparator inputs read as zero
   assign pa_read_w = pa_sync_w & ~i_cmp_analog_sel;
   assign rdata_nxt =
      sel_a_data_w ? {`GPC_PA_PAD, pa_read_w} :
      sel_b_data_w ? pb_sync_w :
      sel_opt_w ? option_r :
      sel_a_dir_w ? {`GPC_PA_PAD, dir_a_r} :
      sel_b_dir_w ? dir_b_r :
      `GPC_RST_BYTE;

   // ============================================================
   // Change detection
   logic chg_flag_w;   // Sticky change flag
   logic chg_miss_w;   // Mismatch present this cycle

   // Upper nibble of bank B against the last accessed value
   gpc_chg_det u_chg
   (
      .i_core_clk (i_core_clk),
      .i_sys_rst (i_sys_rst),
      .i_pins (pb_sync_w[`GPC_PB_CHG_MSB:`GPC_PB_CHG_LSB]),
      .i_dir (dir_b_r[`GPC_PB_CHG_MSB:`GPC_PB_CHG_LSB]),
      .i_snap (b_access_w),
      .i_flag_clr (i_change_flag_clr),
      .o_flag (chg_flag_w),
      .o_mismatch (chg_miss_w)
   );

   // ============================================================
   // Output flops
   gpc_byte_t rdata_r;        // Read data, held until next read
   gpc_bank_a_t pa_out_r;     // Bank A levels
   gpc_bank_a_t pa_oe_r;      // Bank A enables
   gpc_bank_b_t pb_out_r;     // Bank B levels
   gpc_bank_b_t pb_oe_r;      // Bank B enables
   gpc_bank_b_t pb_pu_r;      // Bank B pull-ups
   logic tmr_clk_r;           // Timer external clock
   logic wake_r;              // Wake request

   // All top outputs except the change flag come from here; o_bank_b_change_flag is taken straight from u_chg
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         rdata_r <= `GPC_RST_BYTE;
         pa_out_r <= `GPC_RST_LATCH_A;
         pa_oe_r <= `GPC_RST_LATCH_A;
         pb_out_r <= `GPC_RST_LATCH_B;
         pb_oe_r <= `GPC_RST_LATCH_B;
         pb_pu_r <= `GPC_RST_LATCH_B;
         tmr_clk_r <= 1'h0;
         wake_r <= 1'h0;
      end
      else
      begin
         // Read data only changes on a read
         if (i_reg_rd)
         begin
            rdata_r <= rdata_nxt;
         end
         pa_out_r <= pa_out_nxt;
         pa_oe_r <= pa_oe_nxt;
         pb_out_r <= latch_b_r;
         pb_oe_r <= ~dir_b_r;
         pb_pu_r <= pb_pu_nxt;
         tmr_clk_r <= pa_sync_w[`GPC_PA_OD_BIT];
         wake_r <= chg_flag_w;
      end
   end

   assign o_reg_rdata = rdata_r;
   assign o_pa_out = pa_out_r;
   assign o_pa_oe = pa_oe_r;
   assign o_pb_out = pb_out_r;
   assign o_pb_oe = pb_oe_r;
   assign o_pb_pullup_en = pb_pu_r;
   assign o_timer_ext_clock_in = tmr_clk_r;
   assign o_bank_b_change_flag = chg_flag_w;
   assign o_wake_req = wake_r;

   // ============================================================
   // Assertions

   // Input direction bit floats the bank A driver
   AST_PA_DIR_FLOAT: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      dir_a_r[0] |=> !o_pa_oe[0])
      else $error("bank A pin 0 driven while set as input");

   // Bank A data write lands in the latch next cycle
   AST_PA_WRITE: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      wr_a_data_w |=> latch_a_r == $past(i_reg_wdata[4:0]))
      else $error("bank A latch did not take the write");

   // Upper direction bits read as zero
   AST_PA_DIR_PAD: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (i_reg_rd && sel_a_dir_w) |=> o_reg_rdata[7:5] == 3'h0)
      else $error("bank A direction upper bits not zero");

   // Open-drain pin lets go when set as input or offered a high
   AST_PA_OD: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (dir_a_r[4] || pa_val_w[4]) |=> (!o_pa_oe[4] && !o_pa_out[4]))
      else $error("open drain pin driven high");

   // Comparator input pin reads back zero
   AST_CMP_READ_ZERO: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (i_reg_rd && sel_a_data_w && i_cmp_analog_sel[1])
      |=> !o_reg_rdata[1])
      else $error("comparator input pin read non-zero");

   // After reset all bank A drivers stay off for two cycles
   AST_RESET_INPUTS: assert property (@(posedge i_core_clk)
      $fell(i_sys_rst) |-> (o_pa_oe == 5'h00) [*2])
      else $error("bank A driven right after reset");

   // Pull-up follows option bit and direction
   AST_PULLUP: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (!dir_b_r[2] || option_r[7]) |=> !o_pb_pullup_en[2])
      else $error("pull-up on for output pin or when disabled");

   // An input-pin mismatch sets the flag next cycle
   AST_CHANGE_SET: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      chg_miss_w |=> o_bank_b_change_flag)
      else $error("mismatch did not set change flag");

   // Output-configured upper pins never set the flag
   AST_CHANGE_MASK: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (dir_b_r[7:4] == 4'h0 && !o_bank_b_change_flag)
      |=> !o_bank_b_change_flag)
      else $error("output pins set the change flag");

   // Flag reaches the wake output one cycle later
   AST_WAKE: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      o_bank_b_change_flag |=> o_wake_req)
      else $error("change flag did not raise wake");

   // Bank B direction reaches the drivers two cycles after a write
   AST_PB_DIR: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      wr_b_dir_w |=> ##1 (o_pb_oe == ~$past(i_reg_wdata, 2)))
      else $error("bank B enables do not follow direction write");

   // Bank B latch reaches the pins two cycles after a write
   AST_PB_WRITE: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      wr_b_data_w |=> ##1 (o_pb_out == $past(i_reg_wdata, 2)))
      else $error("bank B drive does not follow data write");

   // Cleared option bit turns on the pull-up of an input pin
   AST_PULLUP_ON: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (!option_r[`GPC_OPT_PULLUP_BIT] && dir_b_r[5]) |=> o_pb_pullup_en[5])
      else $error("pull-up off for input pin while enabled");

   // Pull-ups stay off right after reset
   AST_PULLUP_RESET: assert property (@(posedge i_core_clk)
      $fell(i_sys_rst) |-> (o_pb_pullup_en == 8'h00))
      else $error("pull-up on right after reset");

   // An access with the pins steady leaves no mismatch behind
   AST_ACCESS_ENDS: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (b_access_w ##1 (pb_sync_w[7:4] == $past(pb_sync_w[7:4])))
      |-> !chg_miss_w)
      else $error("mismatch left after bank B access");
endmodule

// [test/gpc_pin_model.sv]
// Model of the circuit outside a pin bank: contacts, pull-ups, floating lines
`timescale 1ns/1ps
module gpc_pin_model
#(
   parameter int W = 8
)
(
   input wire logic i_core_clk,
   input wire logic [W-1:0] i_drv,
   input wire logic [W-1:0] i_oe,
   input wire logic [W-1:0] i_pu,
   input wire logic [W-1:0] i_ext_val,
   input wire logic [W-1:0] i_ext_en,
   output logic [W-1:0] o_level
);
   // ============================================================
   // Floating lines
   logic [W-1:0] float_r = '0; // Last level, inverted each cycle
   logic [W-1:0] drive_w; // Level forced by the device driver
   logic [W-1:0] ext_w; // Level forced by a contact
   logic [W-1:0] pull_w; // Level held by the weak pull-up
   logic [W-1:0] free_w; // Undriven and unpulled lines
   // A released line without pull-up never keeps its last value
   always @(posedge i_core_clk)
   begin
      float_r <= ~o_level;
   end
   // ============================================================
   // Wire resolution: device driver, then contact, then pull-up
   assign drive_w = i_oe & i_drv;
   assign ext_w = ~i_oe & i_ext_en & i_ext_val;
   assign pull_w = ~i_oe & ~i_ext_en & i_pu;
   assign free_w = ~i_oe & ~i_ext_en & ~i_pu & float_r;
   assign o_level = drive_w | ext_w | pull_w | free_w;
endmodule

// [test/dual_gpio_port_change_detect_test.sv]
// Self-checking bench for the two pin banks with change detection
`timescale 1ns/1ps
`include "gpc_regs.svh"
module dual_gpio_port_change_detect_test;
   import gpc_pkg::*;
   // ============================================================
   // Signals
   logic core_clk = 1'b0; // 40 MHz clock
   logic sys_rst, reg_wr, reg_rd, route, flag_clr, tmr_clk, chg_flag, wake;
   logic [7:0] reg_addr; // Register address
   logic [1:0] cmp_out; // Comparator results
   gpc_byte_t wdata, rdata, v, d, o, lb;
   gpc_bank_a_t cmp_sel, pa_in, pa_out, pa_oe, exa_val, la;
   gpc_bank_b_t pb_in, pb_out, pb_oe, pb_pu, exb_val, exb_en;
   gpc_byte_t exp_q[$]; // Expected read data, oldest first
   logic rd_seen = 1'b0; // A read was taken at the last edge
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   always #12.5 core_clk = ~core_clk;
   // ============================================================
   // Device, pin bank models
   gpc_top i_dut (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
      .i_reg_addr(reg_addr), .i_reg_wdata(wdata), .i_reg_wr(reg_wr),
      .i_reg_rd(reg_rd), .o_reg_rdata(rdata), .i_cmp_analog_sel(cmp_sel),
      .i_cmp_out_route(route), .i_cmp_out(cmp_out),
      .i_change_flag_clr(flag_clr), .i_pa_in(pa_in), .o_pa_out(pa_out),
      .o_pa_oe(pa_oe), .i_pb_in(pb_in), .o_pb_out(pb_out),
      .o_pb_oe(pb_oe), .o_pb_pullup_en(pb_pu),
      .o_timer_ext_clock_in(tmr_clk), .o_bank_b_change_flag(chg_flag),
      .o_wake_req(wake));
   gpc_pin_model #(.W(5)) i_bank_a (.i_core_clk(core_clk), .i_drv(pa_out),
      .i_oe(pa_oe), .i_pu(5'h00), .i_ext_val(exa_val), .i_ext_en(5'h1F),
      .o_level(pa_in));
   gpc_pin_model #(.W(8)) i_bank_b (.i_core_clk(core_clk), .i_drv(pb_out),
      .i_oe(pb_oe), .i_pu(pb_pu), .i_ext_val(exb_val), .i_ext_en(exb_en),
      .o_level(pb_in));
   // ============================================================
   // Tasks
   task automatic results();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic cmp_byte(input string what, input gpc_byte_t e,
      input gpc_byte_t g);
      total_checks++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cmp_bit(input string what, input logic e, input logic g);
      total_checks++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %s expected %b seen %b", what, e, g);
      end
   endtask
   // Step to just after the next rising edges
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // One write strobe, then an idle cycle so strobes never touch
   task automatic wr(input logic [7:0] a, input gpc_byte_t x);
      reg_addr = a;
      wdata = x;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask
   // One read strobe; the monitor checks the data
   task automatic rd(input logic [7:0] a, input gpc_byte_t e);
      reg_addr = a;
      reg_rd = 1'b1;
      exp_q.push_back(e);
      tick(1);
      reg_rd = 1'b0;
      tick(1);
   endtask
   task automatic pulse_clr();
      flag_clr = 1'b1;
      tick(1);
      flag_clr = 1'b0;
      tick(1);
   endtask
   // ============================================================
   // Read monitor and hang guard
   always @(posedge core_clk)
   begin
      rd_seen <= reg_rd & ~sys_rst;
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         failures++;
         results();
      end
   end
   always @(negedge core_clk)
   begin
      if (rd_seen === 1'b1)
         cmp_byte("read data", exp_q.pop_front(), rdata);
   end
   // ============================================================
   // Main sequence
   initial
   begin
      {reg_wr, reg_rd, route, flag_clr, cmp_out} = '0;
      sys_rst = 1'b1;
      reg_addr = 8'h00;
      wdata = 8'h00;
      cmp_sel = 5'h00;
      exa_val = 5'h00;
      exb_val = 8'hFF;
      exb_en = 8'hFF;
      void'($urandom(23363));
      tick(16);
      sys_rst = 1'b0;
      tick(1);
      // Reset state
      cmp_byte("bank A enable", 8'h00, {3'h0, pa_oe});
      cmp_byte("pull-up enable", 8'h00, pb_pu);
      rd(`GPC_ADDR_BANK_A_DIR, 8'h1F);
      rd(`GPC_ADDR_BANK_B_DIR, 8'hFF);
      rd(`GPC_ADDR_OPTION, 8'hFF);
      rd(8'h07, 8'h00);
      // Bank A: mixed directions, analog selections
      for (int n = 0; n < 4; n++)
      begin
         v = 8'($urandom);
         d = 8'($urandom);
         cmp_sel = 5'($urandom);
         exa_val = 5'($urandom);
         wr(`GPC_ADDR_BANK_A_DATA, v);
         wr(`GPC_ADDR_BANK_A_DIR, d);
         la = {~d[4] & ~v[4], ~d[3:0]};
         cmp_byte("bank A enable", {3'h0, la}, {3'h0, pa_oe});
         cmp_byte("bank A drive", {4'h0, v[3:0]}, {3'h0, pa_out});
         la = (la & {1'b0, v[3:0]}) | (~la & exa_val);
         tick(3);
         rd(`GPC_ADDR_BANK_A_DATA, {3'h0, la & ~cmp_sel});
         rd(`GPC_ADDR_BANK_A_DIR, {3'h0, d[4:0]});
         cmp_bit("timer clock", la[4], tmr_clk);
      end
      // Comparator results routed to pins 3 and 4
      route = 1'b1;
      cmp_out = 2'($urandom);
      wr(`GPC_ADDR_BANK_A_DIR, 8'h00);
      cmp_byte("routed drive", {4'h0, cmp_out[0], v[2:0]},
         {3'h0, pa_out});
      cmp_byte("routed enable", {3'h0, ~cmp_out[1], 4'hF},
         {3'h0, pa_oe});
      wr(`GPC_ADDR_BANK_A_DIR, 8'h18);
      cmp_byte("routed enable", 8'h07, {3'h0, pa_oe});
      route = 1'b0;
      // Bank B: directions, latches, pull-ups
      for (int n = 0; n < 4; n++)
      begin
         v = 8'($urandom);
         d = 8'($urandom);
         o = 8'($urandom);
         exb_val = 8'($urandom);
         exb_en = o[7] ? 8'hFF : 8'($urandom);
         wr(`GPC_ADDR_BANK_B_DATA, v);
         wr(`GPC_ADDR_BANK_B_DIR, d);
         wr(`GPC_ADDR_OPTION, o);
         cmp_byte("bank B enable", ~d, pb_oe);
         cmp_byte("bank B drive", v, pb_out);
         cmp_byte("pull-up enable", o[7] ? 8'h00 : d, pb_pu);
         lb = (~d & v) | (d & exb_en & exb_val) | (d & ~exb_en);
         tick(3);
         rd(`GPC_ADDR_BANK_B_DATA, lb);
         rd(`GPC_ADDR_OPTION, o);
      end
      // Change detection on each upper pin
      wr(`GPC_ADDR_OPTION, 8'hFF);
      exb_en = 8'hFF;
      exb_val = 8'($urandom);
      v = 8'($urandom);
      wr(`GPC_ADDR_BANK_B_DATA, v);
      wr(`GPC_ADDR_BANK_B_DIR, 8'hF0);
      tick(3);
      rd(`GPC_ADDR_BANK_B_DATA, {exb_val[7:4], v[3:0]});
      pulse_clr();
      cmp_bit("change flag", 1'b0, chg_flag);
      for (int p = 4; p < 8; p++)
      begin
         exb_val[p] = ~exb_val[p];
         // Wait for the flag without polling the bank
         for (int k = 0; k < 8 && chg_flag !== 1'b1; k++)
            tick(1);
         cmp_bit("change flag", 1'b1, chg_flag);
         tick(1);
         cmp_bit("wake request", 1'b1, wake);
         pulse_clr();
         cmp_bit("change flag", 1'b1, chg_flag);
         rd(`GPC_ADDR_BANK_B_DATA, {exb_val[7:4], v[3:0]});
         pulse_clr();
         cmp_bit("change flag", 1'b0, chg_flag);
      end
      // An output pin that differs from the snapshot is ignored
      wr(`GPC_ADDR_BANK_B_DATA, {~exb_val[7], v[6:0]});
      pulse_clr();
      wr(`GPC_ADDR_BANK_B_DIR, 8'h70);
      tick(6);
      cmp_bit("change flag", 1'b0, chg_flag);
      // Whole upper nibble as outputs: nothing is compared
      wr(`GPC_ADDR_BANK_B_DIR, 8'h00);
      tick(6);
      cmp_bit("change flag", 1'b0, chg_flag);
      tick(2);
      if (exp_q.size() != 0)
         failures++;
      results();
   end
endmodule
